// ---- rtl/bds_sram.sv ----
// Burst-of-four common-I/O DDR SRAM core with loop and impedance control
module bds_sram
    import bds_pkg::*;
#(
    parameter int WORD_W = BDS_WORD_W,
    parameter int ADDR_W = BDS_ADDR_W,
    parameter int IMP_W = BDS_IMP_W
) (
    // System clock and reset
    input logic clk,
    input logic reset_n,
    // Link clock, one tick per K or K-bar rising edge
    input logic link_clk,
    input logic k_edge_is_true,
    // Command and address
    input logic load_strobe_n,
    input logic read_write_select,
    input logic [ADDR_W-1:0] address_upper,
    input logic burst_count_address_low,
    input logic burst_count_address_high,
    // Byte lanes
    input logic byte_lane0_write_n,
    input logic byte_lane1_write_n,
    input logic byte_lane2_write_n,
    input logic byte_lane3_write_n,
    // Shared data bus
    input logic [WORD_W-1:0] dq_in,
    output logic [WORD_W-1:0] dq_out,
    output logic dq_oe,
    // Output timing clocks and echo strobes
    input logic out_clk_p,
    input logic out_clk_n,
    output logic returned_strobe_pair_p,
    output logic returned_strobe_pair_n,
    output logic single_clock_mode,
    // Delay loop and impedance
    input logic dll_enable,
    output logic dll_locked,
    input logic [IMP_W-1:0] impedance_target,
    output logic [IMP_W-1:0] impedance_code,
    output logic impedance_settled
);
    localparam int LANES = WORD_W / BDS_LANE_W;
    localparam int WA_W = ADDR_W + 2;

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] absent_sync;
        logic [1:0] dll_sync;
        logic [3:0] oclk_sync;
        logic [2*IMP_W-1:0] imp_sync;
        logic pend_valid;
        logic pend_read;
        logic [ADDR_W-1:0] pend_addr;
        logic [1:0] pend_low;
        bds_burst_e state;
        logic [1:0] beat;
        logic [ADDR_W-1:0] addr_hi;
        logic [1:0] addr_low;
        logic [WORD_W-1:0] dq_out;
        logic dq_oe;
        logic echo;
        logic echo_n;
        logic tick;
        logic strap_taken;
        logic single_mode;
        logic [10:0] lock_cnt;
        logic locked;
        logic [IMP_W-1:0] imp_code;
        logic [10:0] quiet_cnt;
        logic settled;
    } bds_link_s;

    typedef struct packed {
        logic [2:0] tick_sync;
        logic [4:0] idle_cnt;
        logic absent;
    } bds_sys_s;

    bds_link_s cur;
    bds_link_s next_cur;
    bds_sys_s sys;
    bds_sys_s next_sys;

    logic [WORD_W-1:0] mem [0:(1 << WA_W)-1];
    logic [3:0] lane_n_all;
    logic [1:0] pin_low;
    logic [BDS_LANE_W-1:0] lane0_in;
    logic burst_start;
    logic cmd_take;
    logic active;
    logic rd_now;
    logic wr_now;
    logic [1:0] beat_idx;
    logic [WA_W-1:0] word_addr;
    logic mem_we;
    logic [WA_W-1:0] mem_wa;

    assign lane_n_all = {byte_lane3_write_n, byte_lane2_write_n,
                         byte_lane1_write_n, byte_lane0_write_n};
    assign pin_low = {burst_count_address_high, burst_count_address_low};
    assign lane0_in = dq_in[BDS_LANE_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Link domain

    always_comb begin
        next_cur = cur;
        burst_start = 1'b0;
        cmd_take = 1'b0;
        rd_now = 1'b0;
        wr_now = 1'b0;
        beat_idx = BDS_BEAT_FIRST;
        word_addr = '0;
        mem_we = 1'b0;
        mem_wa = '0;
        active = (cur.state != BDS_IDLE);
        if (!cur.rst_sync[1]) begin
            next_cur = '0;
            next_cur.state = BDS_IDLE;
            next_cur.echo_n = 1'b1;
        end else begin
            next_cur.tick = ~cur.tick;
            next_cur.echo = ~cur.echo;
            next_cur.echo_n = cur.echo;
            // Mode strap caught once after reset release
            if (!cur.strap_taken) begin
                next_cur.strap_taken = 1'b1;
                next_cur.single_mode = &cur.oclk_sync[3:2];
            end
            // Loop lock counts K edges; absence restarts it
            if (!cur.dll_sync[1] || cur.absent_sync[1]) begin
                next_cur.lock_cnt = '0;
                next_cur.locked = 1'b0;
            end else if (k_edge_is_true && !cur.locked) begin
                next_cur.lock_cnt = cur.lock_cnt + BDS_CNT_ONE;
                next_cur.locked = (next_cur.lock_cnt == BDS_LOCK_CYCLES);
            end
            // Burst engine, pending command starts at next K edge
            burst_start = k_edge_is_true && cur.pend_valid && !active;
            if (burst_start) begin
                next_cur.pend_valid = 1'b0;
                next_cur.state = cur.pend_read ? BDS_READ_BURST
                                               : BDS_WRITE_BURST;
                // Write address is taken at this later edge
                next_cur.addr_hi = cur.pend_read ? cur.pend_addr
                                                 : address_upper;
                next_cur.addr_low = cur.pend_read ? cur.pend_low : pin_low;
                next_cur.beat = BDS_BEAT_STEP;
                rd_now = cur.pend_read;
                wr_now = !cur.pend_read;
            end else if (active) begin
                beat_idx = cur.beat;
                next_cur.beat = cur.beat + BDS_BEAT_STEP;
                rd_now = (cur.state == BDS_READ_BURST);
                wr_now = (cur.state == BDS_WRITE_BURST);
                if (cur.beat == BDS_BEAT_LAST) begin
                    next_cur.state = BDS_IDLE;
                end
            end
            word_addr = {next_cur.addr_hi,
                         2'(next_cur.addr_low + beat_idx)};
            if (rd_now) begin
                next_cur.dq_out = mem[word_addr];
                next_cur.dq_oe = 1'b1;
            end else begin
                next_cur.dq_oe = 1'b0;
            end
            // Data only lands during a write burst
            mem_we = wr_now;
            mem_wa = word_addr;
            // New command, one per two K cycles
            cmd_take = k_edge_is_true && !load_strobe_n
                       && !cur.pend_valid
                       && (!active || cur.beat >= BDS_BEAT_HALF);
            if (cmd_take) begin
                next_cur.pend_valid = 1'b1;
                next_cur.pend_read = read_write_select;
                next_cur.pend_addr = address_upper;
                next_cur.pend_low = pin_low;
            end
            // Impedance moves only while the bus is quiet
            if (!cur.dq_oe && !next_cur.dq_oe) begin
                next_cur.imp_code =
                    cur.imp_sync[2*IMP_W-1:IMP_W];
            end
            if (k_edge_is_true && !rd_now
                && cur.quiet_cnt != BDS_QUIET_CYCLES) begin
                next_cur.quiet_cnt = cur.quiet_cnt + BDS_CNT_ONE;
            end
            next_cur.settled = (next_cur.quiet_cnt == BDS_QUIET_CYCLES);
        end
        next_cur.rst_sync = {cur.rst_sync[0], reset_n};
        next_cur.absent_sync = {cur.absent_sync[0], sys.absent};
        next_cur.dll_sync = {cur.dll_sync[0], dll_enable};
        next_cur.oclk_sync = {cur.oclk_sync[1:0], out_clk_p, out_clk_n};
        next_cur.imp_sync = {cur.imp_sync[IMP_W-1:0], impedance_target};
    end

    always_ff @(posedge link_clk) begin
        cur <= next_cur;
    end

    always_ff @(posedge link_clk) begin
        for (int l = 0; l < LANES; l++) begin
            if (mem_we && !lane_n_all[l]) begin
                mem[mem_wa][l*BDS_LANE_W +: BDS_LANE_W] <=
                    dq_in[l*BDS_LANE_W +: BDS_LANE_W];
            end
        end
    end

    assign dq_out = cur.dq_out;
    assign dq_oe = cur.dq_oe;
    assign returned_strobe_pair_p = cur.echo;
    assign returned_strobe_pair_n = cur.echo_n;
    assign single_clock_mode = cur.single_mode;
    assign dll_locked = cur.locked;
    assign impedance_code = cur.imp_code;
    assign impedance_settled = cur.settled;

    ////////////////////////////////////////////////////////////////////////
    // System domain: link clock absence watch

    always_comb begin
        next_sys = sys;
        next_sys.tick_sync = {sys.tick_sync[1:0], cur.tick};
        if (!reset_n) begin
            next_sys.idle_cnt = '0;
            next_sys.absent = 1'b0;
        end else if (sys.tick_sync[2] != sys.tick_sync[1]) begin
            next_sys.idle_cnt = '0;
            next_sys.absent = 1'b0;
        end else if (sys.idle_cnt == BDS_ABSENT_COUNT) begin
            next_sys.absent = 1'b1;
        end else begin
            next_sys.idle_cnt = sys.idle_cnt + BDS_IDLE_ONE;
        end
    end

    always_ff @(posedge clk) begin
        sys <= next_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge link_clk); endclocking
    default disable iff (!cur.rst_sync[1]);

    property p_read_take;
        cmd_take && read_write_select |=>
            cur.pend_read && cur.pend_addr == $past(address_upper);
    endproperty
    a_read_take: assert property (p_read_take)
        else $error("read command address not kept");

    property p_burst_four;
        burst_start |=> (cur.state != BDS_IDLE) [*3]
            ##1 (cur.state == BDS_IDLE);
    endproperty
    a_burst_four: assert property (p_burst_four)
        else $error("burst is not four words long");

    property p_first_word;
        burst_start && cur.pend_read |=>
            cur.dq_oe && cur.beat == BDS_BEAT_STEP;
    endproperty
    a_first_word: assert property (p_first_word)
        else $error("first read word not driven");

    property p_read_drive;
        cur.state == BDS_READ_BURST |-> cur.dq_oe;
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("read burst with bus released");

    property p_single_mode;
        cur.strap_taken |=> $stable(cur.single_mode);
    endproperty
    a_single_mode: assert property (p_single_mode)
        else $error("clock mode changed after reset");

    property p_deselect;
        cur.state == BDS_READ_BURST && cur.beat == BDS_BEAT_LAST
            && !cur.pend_valid |=> ##1 !cur.dq_oe;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("bus not released after last read word");

    property p_write_addr;
        burst_start && !cur.pend_read |=>
            cur.addr_hi == $past(address_upper)
            && cur.state == BDS_WRITE_BURST;
    endproperty
    a_write_addr: assert property (p_write_addr)
        else $error("write address not taken at start");

    property p_write_gate;
        mem_we |-> cur.state == BDS_WRITE_BURST || burst_start;
    endproperty
    a_write_gate: assert property (p_write_gate)
        else $error("write outside a write burst");

    property p_lane_mask;
        mem_we && !byte_lane0_write_n |=>
            mem[$past(mem_wa)][BDS_LANE_W-1:0] == $past(lane0_in);
    endproperty
    a_lane_mask: assert property (p_lane_mask)
        else $error("enabled lane not written");

    property p_imp_quiet;
        $changed(cur.imp_code) |-> !cur.dq_oe && !$past(cur.dq_oe);
    endproperty
    a_imp_quiet: assert property (p_imp_quiet)
        else $error("impedance changed while driving");

    property p_echo;
        1'b1 |=> cur.echo != $past(cur.echo) && cur.echo != cur.echo_n;
    endproperty
    a_echo: assert property (p_echo)
        else $error("echo strobes not toggling in opposition");

    property p_dll_absent;
        cur.absent_sync[1] |=> !cur.locked && cur.lock_cnt == '0;
    endproperty
    a_dll_absent: assert property (p_dll_absent)
        else $error("loop not reset on absent clock");

    c_read: cover property (burst_start && cur.pend_read);
    c_write: cover property (burst_start && !cur.pend_read);
    c_back_to_back: cover property (cur.state == BDS_READ_BURST
        && cur.beat == BDS_BEAT_LAST ##1 burst_start && cur.pend_read);
    c_locked: cover property ($rose(cur.locked));
endmodule

// ---- rtl/bds_pkg.sv ----
// Constants and types for the burst-of-four common-I/O DDR SRAM core
// Function
// - Read command taken at K edge: select high, load strobe low; address kept.
// - Every command moves exactly four words of 36 or 18 bits.
// - First read word follows the next K edge; second on the next edge.
// - Back-to-back reads present one word on every output clock edge.
// - With both output clocks held high, read data is timed from K clocks.
// - After a read, finish the burst, deselect at next K edge, tristate.
// - Write command taken at K edge with select low; address at next K edge.
// - Write words taken on consecutive K and K-bar edges from next K edge.
// - Deselect ignores data presented while the load strobe is inactive.
// - Each active-low lane enable gates one nine-bit slice of write data.
// - A deselected device still completes all pending reads and writes.
// - Output impedance only changes in cycles where the outputs are not driven.
// - A complementary echo strobe pair runs continuously with the output timing.
// - After input clocks restart, 1024 cycles pass before normal operation.
// - The delay loop resets whenever the input clock is seen to be absent.
// - Burst words follow linear order from the supplied two low bits, modulo four.
package bds_pkg;
    localparam int BDS_WORD_W = 36;
    localparam int BDS_ADDR_W = 19;
    localparam int BDS_LANE_W = 9;
    localparam int BDS_IMP_W = 6;
    localparam logic [1:0] BDS_BEAT_FIRST = 2'h0;
    localparam logic [1:0] BDS_BEAT_STEP = 2'h1;
    localparam logic [1:0] BDS_BEAT_HALF = 2'h2;
    localparam logic [1:0] BDS_BEAT_LAST = 2'h3;
    localparam logic [10:0] BDS_LOCK_CYCLES = 11'h400;
    localparam logic [10:0] BDS_QUIET_CYCLES = 11'h400;
    localparam logic [10:0] BDS_CNT_ONE = 11'h001;
    localparam int BDS_CLK_PERIOD_PS = 4000;
    localparam int BDS_ABSENT_NS = 60;
    localparam int BDS_ABSENT_CYC =
        (BDS_ABSENT_NS * 1000 + BDS_CLK_PERIOD_PS - 1) / BDS_CLK_PERIOD_PS;
    localparam logic [4:0] BDS_ABSENT_COUNT = 5'(BDS_ABSENT_CYC);
    localparam logic [4:0] BDS_IDLE_ONE = 5'h01;
    typedef enum logic [1:0] {
        BDS_IDLE = 2'b00,
        BDS_READ_BURST = 2'b01,
        BDS_WRITE_BURST = 2'b10
    } bds_burst_e;
endpackage

// ---- verification/bds_ctrl.sv ----
// Memory controller model driving the link side of the SRAM core
module bds_ctrl
    import bds_pkg::*;
(
    // Link clock and phase
    output logic link_clk,
    output logic k_edge_is_true,
    // Command, address, lanes, write data
    output logic load_strobe_n,
    output logic read_write_select,
    output logic [7:0] addr,
    output logic [3:0] lane_n,
    output logic [BDS_WORD_W-1:0] dq_in,
    // Output clocks and read side
    output logic out_clk_p,
    output logic out_clk_n,
    input logic single,
    input logic [BDS_WORD_W-1:0] dq_out,
    input logic dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 85;
    logic run_clk = 1'b1;
    logic busy = 1'b0;
    logic rd [32];
    logic [7:0] ca [32];
    logic [3:0] cl [32];
    logic [BDS_WORD_W-1:0] wd [32][4];
    logic [BDS_WORD_W-1:0] got [32][4];
    logic oe_seen [136];
    // Both output clocks high selects single-clock timing
    assign out_clk_p = single | k_edge_is_true;
    assign out_clk_n = single | ~k_edge_is_true;
    task automatic idle();
        load_strobe_n = 1'b1;
        read_write_select = 1'($random(seed));
        addr = 8'($random(seed));
        lane_n = 4'($random(seed));
        dq_in = ~dq_in; // Released bus shows no stale word
    endtask
    initial begin
        link_clk = 1'b0;
        k_edge_is_true = 1'b1;
        dq_in = '0;
        idle();
        #7.3;
        forever begin
            #15;
            link_clk = run_clk ? ~link_clk : 1'b0;
        end
    end
    always @(posedge link_clk) k_edge_is_true <= ~k_edge_is_true;
    always @(negedge link_clk) if (!busy) idle();
    // Each input assigned once per tick; strobe random at K-bar
    task automatic drive(input int t, input int n);
        int w;
        logic cmd_now;
        logic wr_now;
        w = t - 2;
        cmd_now = t % 4 == 0 && t / 4 < n;
        wr_now = w >= 0 && w / 4 < n && !rd[w / 4];
        load_strobe_n = cmd_now ? 1'b0
                      : t[0] ? 1'($random(seed)) : 1'b1;
        read_write_select = cmd_now ? rd[t / 4] : 1'($random(seed));
        addr = cmd_now ? ca[t / 4]
             : (wr_now && w % 4 == 0) ? ca[w / 4] : 8'($random(seed));
        lane_n = wr_now ? cl[w / 4] : 4'($random(seed));
        dq_in = wr_now ? wd[w / 4][w % 4] : ~dq_in;
    endtask
    // Commands every two K cycles, data on both edges
    task automatic run(input int n);
        busy = 1'b1;
        do @(negedge link_clk); while (!k_edge_is_true);
        for (int t = 0; t < 4 * n + 7; t++) begin
            drive(t, n);
            @(negedge link_clk);
            oe_seen[t] = dq_oe;
            if (t >= 2 && (t - 2) / 4 < n) got[(t - 2) / 4][(t - 2) % 4] = dq_out;
        end
        busy = 1'b0;
    endtask
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the burst-of-four DDR SRAM core
module testbench
    import bds_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic dll_enable = 1'b0;
    logic single = 1'b0;
    logic imp_rand = 1'b1;
    logic echo_on = 1'b0;
    logic [5:0] impedance_target = 6'h00;
    logic link_clk, k_edge_is_true, load_strobe_n, read_write_select;
    logic dq_oe, echo_p, echo_n, pecho, poe, out_clk_p, out_clk_n;
    logic single_clock_mode, dll_locked, impedance_settled;
    logic [7:0] addr;
    logic [3:0] lane_n;
    logic [5:0] impedance_code, pcode;
    logic [BDS_WORD_W-1:0] dq_in, dq_out;
    logic [BDS_WORD_W-1:0] mem [256];
    logic [BDS_WORD_W-1:0] expd [32][4];
    int seed = 85;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    int kt;
    always #2 clk = ~clk;
    bds_sram #(.ADDR_W(6)) dut (
        .clk(clk), .reset_n(reset_n), .link_clk(link_clk),
        .k_edge_is_true(k_edge_is_true), .load_strobe_n(load_strobe_n),
        .read_write_select(read_write_select), .address_upper(addr[7:2]),
        .burst_count_address_low(addr[0]),
        .burst_count_address_high(addr[1]),
        .byte_lane0_write_n(lane_n[0]), .byte_lane1_write_n(lane_n[1]),
        .byte_lane2_write_n(lane_n[2]), .byte_lane3_write_n(lane_n[3]),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .out_clk_p(out_clk_p), .out_clk_n(out_clk_n),
        .returned_strobe_pair_p(echo_p), .returned_strobe_pair_n(echo_n),
        .single_clock_mode(single_clock_mode), .dll_enable(dll_enable),
        .dll_locked(dll_locked), .impedance_target(impedance_target),
        .impedance_code(impedance_code),
        .impedance_settled(impedance_settled)
    );
    bds_ctrl ctl (
        .link_clk(link_clk), .k_edge_is_true(k_edge_is_true),
        .load_strobe_n(load_strobe_n),
        .read_write_select(read_write_select), .addr(addr),
        .lane_n(lane_n), .dq_in(dq_in), .out_clk_p(out_clk_p),
        .out_clk_n(out_clk_n), .single(single), .dq_out(dq_out),
        .dq_oe(dq_oe)
    );
    ////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    function automatic logic [BDS_WORD_W-1:0] mask(input logic [3:0] ln);
        for (int i = 0; i < 4; i++) mask[i * 9 +: 9] = {9{~ln[i]}};
    endfunction
    task automatic cmd(input int k, input logic r, input int up,
                       input logic [3:0] ln);
        int a;
        ctl.rd[k] = r;
        ctl.ca[k] = {6'(up), 2'($random(seed))};
        ctl.cl[k] = ln;
        for (int j = 0; j < 4; j++) begin
            a = up * 4 + (ctl.ca[k][1:0] + j) % 4;
            ctl.wd[k][j] = {$random(seed), 4'($random(seed))};
            if (r) expd[k][j] = mem[a];
            else mem[a] = mem[a] & ~mask(ln)
                          | ctl.wd[k][j] & mask(ln);
        end
    endtask
    task automatic check_run(input int n);
        logic w;
        int q;
        int e;
        ctl.run(n);
        for (int t = 0; t < 4 * n + 7; t++) begin
            q = (t - 2) / 4;
            e = (t - 2) % 4;
            w = t >= 2 && q < n && ctl.rd[q];
            check(ctl.oe_seen[t] === w, "bus drive window");
            if (w) check(ctl.got[q][e] === expd[q][e], "read");
        end
    endtask
    task automatic reads(input int base, input int n);
        for (int k = 0; k < n; k++) cmd(k, 1'b1, base + k, 4'h0);
        check_run(n);
    endtask
    task automatic do_reset();
        @(negedge clk) reset_n = 1'b0;
        repeat (16) @(posedge clk);
        repeat (3) @(posedge link_clk);
        @(negedge clk) reset_n = 1'b1;
        repeat (8) @(posedge link_clk);
    endtask
    task automatic wait_lock();
        kt = 0;
        while (dll_locked !== 1'b1 && kt < 1100) begin
            @(posedge link_clk);
            if (k_edge_is_true) kt++;
        end
        check(dll_locked === 1'b1, "loop lock");
    endtask
    ////////////////////////////////////////////////////////////////////
    always @(negedge link_clk) begin
        if (echo_on) begin
            check(echo_p === ~echo_n && echo_p !== pecho, "echo");
            check(impedance_code === pcode || !dq_oe && !poe,
                  "impedance moved while driving");
        end
        pecho = echo_p;
        pcode = impedance_code;
        poe = dq_oe;
    end
    always @(negedge clk) begin
        cycles++;
        if (imp_rand && $random(seed) % 97 == 0)
            impedance_target <= 6'($random(seed));
        if (cycles == 60000) begin
            fails++;
            results();
        end
    end
    initial begin
        do_reset();
        @(negedge clk) dll_enable = 1'b1;
        wait_lock();
        check(kt >= 1024 && kt <= 1040, "lock time");
        check(impedance_settled === 1'b1, "impedance settle");
        check(single_clock_mode === 1'b0, "clock mode");
        echo_on = 1'b1;
        for (int k = 0; k < 32; k++) cmd(k, 1'b0, k, 4'h0);
        check_run(32);
        for (int k = 0; k < 32; k++) begin
            if ($random(seed) % 2) cmd(k, 1'b1, k % 16, 4'h0);
            else cmd(k, 1'b0, 16 + k % 16, 4'($random(seed)));
        end
        check_run(32);
        reads(16, 16);
        imp_rand = 1'b0;
        @(negedge clk) impedance_target = 6'h2a;
        repeat (40) @(posedge link_clk);
        check(impedance_code === 6'h2a, "impedance update");
        echo_on = 1'b0;
        single = 1'b1;
        do_reset();
        wait_lock();
        check(single_clock_mode === 1'b1, "single clock");
        echo_on = 1'b1;
        reads(16, 16);
        echo_on = 1'b0;
        ctl.run_clk = 1'b0;
        #200;
        ctl.run_clk = 1'b1;
        repeat (8) @(posedge link_clk);
        check(dll_locked === 1'b0, "loop reset on stop");
        wait_lock();
        check(kt >= 1012 && kt <= 1040, "restart time");
        echo_on = 1'b1;
        reads(0, 8);
        results();
    end
endmodule
